// ===== common/sdlc_line_cfg.svh
`ifndef SDLC_LINE_CFG_SVH
`define SDLC_LINE_CFG_SVH

// ============================================================
// Register byte offsets
`define OFS_CTRL     5'h00
`define OFS_BAUD     5'h04
`define OFS_ADDR     5'h08
`define OFS_MASK     5'h0C
`define OFS_TXDATA   5'h10
`define OFS_RXDATA   5'h14
`define OFS_STATUS   5'h18

// ============================================================
// Control field positions
`define CTL_SDLC     0
`define CTL_CRC32    1
`define CTL_HALF     2
`define CTL_REN      3
`define CTL_AREN     4
`define CTL_ALT_USE  5
`define CTL_TEN      6
`define CTL_BRG      7
`define CTL_HW_ACK   8
`define CTL_CSMA     9
`define CTL_PRE_LO   12
`define CTL_PRE_HI   15

// ============================================================
// Status field positions, then the last-byte bit of a TXDATA write
`define ST_HOLD_FULL 0
`define ST_TX_BUSY   1
`define ST_RX_VALID  2
`define ST_RX_DONE   3
`define ST_CRC_ERR   4
`define ST_ALIGN_ERR 5
`define ST_HALF      6
`define ST_CRC32     7
`define ST_RX_IN     8
`define ST_OVERRUN   9
`define TX_LAST_BIT  8

// ============================================================
// Reset values, line patterns and check constants
`define CTRL_RST     16'h0000
`define BAUD_RST     16'h0000
`define PRE_BYTE     8'h55
`define FLAG_BYTE    8'h7E
`define BCAST_ADDR   8'hFF
`define CRC_INIT     32'hFFFFFFFF
`define POLY16       16'h1021
`define POLY32       32'h04C11DB7
`define RESID16      16'h1D0F
`define RESID32      32'hC704DD7B
`define CRC16_BITS   5'h0F
`define CRC32_BITS   5'h1F

`endif

// ===== common/sdlc_line_pkg.sv
package sdlc_line_pkg;

   typedef enum logic [2:0] {
      TX_IDLE,
      TX_PRE,
      TX_OPEN,
      TX_DATA,
      TX_CRC,
      TX_CLOSE
   } tx_e;

   typedef struct packed {
      logic       clr;
      logic       en;
      logic [7:0] data;
   } crc_req_s;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] baud;
      logic [7:0]  addr;
      logic [7:0]  mask;
      logic [7:0]  hold;
      logic        hold_last;
      logic        hold_full;
      logic [15:0] div;
      logic        tick;
      tx_e         tx_st;
      logic [7:0]  tx_sh;
      logic [31:0] crc_sh;
      logic [4:0]  tx_bits;
      logic [3:0]  pre_left;
      logic        tx_last;
      logic        txd;
      logic        rx_s1;
      logic        rx_s2;
      logic        rx_prev;
      logic [7:0]  rx_sh;
      logic [2:0]  rx_cnt;
      logic        rx_in;
      logic        rx_got;
      logic        rx_acc;
      logic [7:0]  pend0;
      logic [7:0]  pend1;
      logic [1:0]  pend_n;
      logic [7:0]  rx_data;
      logic        rx_valid;
      logic        rx_done;
      logic        crc_err;
      logic        align_err;
      logic        overrun;
      logic        eff_half;
      logic        eff_crc32;
      logic        waitreq;
      logic [31:0] rdata;
   } core_s;

endpackage : sdlc_line_pkg

// ===== hw/frame_check_gen.sv
`timescale 1ns/10ps
`include "sdlc_line_cfg.svh"

module frame_check_gen #(
   parameter int W = 32
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_b,
   input  wire sdlc_line_pkg::crc_req_s req,
   input  wire logic                   wide,
   output logic [W-1:0]                crc,
   output logic                        match
);

   logic [W-1:0] crc_r;
   logic [W-1:0] crc_nxt;
   logic [W-1:0] poly;
   logic         fb;

   assign poly  = wide ? W'(`POLY32) : W'(`POLY16);
   assign crc   = crc_r;
   // In narrow mode only the low half counts; the wide engine doubles as
   // a second 16-bit generator when both paths run together
   assign match = wide ? (crc_r == W'(`RESID32))
                       : (crc_r[15:0] == `RESID16);

   // ============================================================
   // Byte-at-a-time update, bits in line order
   always_comb
   begin
      crc_nxt = crc_r;
      fb      = 1'b0;
      if (req.clr)
      begin
         crc_nxt = W'(`CRC_INIT);
      end
      else if (req.en)
      begin
         for (int i = 0; i < 8; i++)
         begin
            fb      = req.data[i] ^ (wide ? crc_nxt[W-1] : crc_nxt[15]);
            crc_nxt = {crc_nxt[W-2:0], 1'b0} ^ ({W{fb}} & poly);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         crc_r <= W'(`CRC_INIT);
      else
         crc_r <= crc_nxt;
   end

endmodule : frame_check_gen

// ===== hw/frame_serial_controller.sv
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "sdlc_line_cfg.svh"

module frame_serial_controller (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rxd,
   output logic             txd
);

   localparam sdlc_line_pkg::core_s CORE_RST = '{
      ctrl:     `CTRL_RST,
      baud:     `BAUD_RST,
      tx_st:    sdlc_line_pkg::TX_IDLE,
      txd:      1'b1,
      rx_s1:    1'b1,
      rx_s2:    1'b1,
      rx_prev:  1'b1,
      waitreq:  1'b1,
      default:  '0
   };

   sdlc_line_pkg::core_s    r;
   sdlc_line_pkg::core_s    n;
   sdlc_line_pkg::crc_req_s wide_req;
   sdlc_line_pkg::crc_req_s narrow_req;
   logic [31:0] crc_w;
   logic [15:0] crc_n;
   logic        match_w;
   logic        match_n;
   logic [4:0]  byte_addr;
   logic        acc;
   logic        done;
   logic [31:0] wmask;
   logic        nrzi;
   logic        tx_bit;
   logic        byte_end;
   logic        rx_on;
   logic        rx_bit;
   logic [7:0]  sh_next;
   logic        quiet;
   logic        want_half;
   logic        tx_clr;
   logic        tx_en;
   logic [7:0]  tx_byte;
   logic        rx_clr;
   logic        rx_en;
   logic        mode_chg;
   logic        ok_addr;
   logic        rx_match;

   // ============================================================
   // Check generators
   frame_check_gen #(.W(32)) u_wide_gen (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .req     (wide_req),
      .wide    (r.eff_crc32),
      .crc     (crc_w),
      .match   (match_w)
   );

   frame_check_gen #(.W(16)) u_narrow_gen (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .req     (narrow_req),
      .wide    (1'b0),
      .crc     (crc_n),
      .match   (match_n)
   );

   // Transmit always owns the wide engine; receive borrows it only in
   // 32-bit mode, where the transmitter is idle by construction
   always_comb
   begin
      wide_req.clr    = tx_clr | mode_chg | (r.eff_crc32 & rx_clr);
      wide_req.en     = tx_en | (r.eff_crc32 & rx_en);
      wide_req.data   = tx_en ? tx_byte : sh_next;
      narrow_req.clr  = mode_chg | (~r.eff_crc32 & rx_clr);
      narrow_req.en   = ~r.eff_crc32 & rx_en;
      narrow_req.data = sh_next;
   end

   assign rx_match = r.eff_crc32 ? match_w : match_n;

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : be_mask

   // ============================================================
   // Next-state logic
   always_comb
   begin
      n         = r;
      tx_clr    = 1'b0;
      tx_en     = 1'b0;
      tx_byte   = r.hold;
      rx_clr    = 1'b0;
      rx_en     = 1'b0;
      mode_chg  = 1'b0;
      ok_addr   = 1'b0;
      byte_addr = {avs_address, 2'b00};
      acc       = (avs_read | avs_write) & r.waitreq;
      done      = (avs_read | avs_write) & ~r.waitreq;
      wmask     = be_mask(avs_byteenable);
      nrzi      = r.ctrl[`CTL_SDLC] & r.ctrl[`CTL_BRG];
      rx_on     = r.ctrl[`CTL_REN]
                  & (~r.ctrl[`CTL_ALT_USE] | r.ctrl[`CTL_AREN])
                  & ~(r.eff_crc32 & (r.tx_st != sdlc_line_pkg::TX_IDLE));
      rx_bit    = nrzi ? (r.rx_s2 == r.rx_prev) : r.rx_s2;
      sh_next   = {rx_bit, r.rx_sh[7:1]};
      tx_bit    = 1'b1;
      byte_end  = (r.tx_bits[2:0] == 3'h7);
      quiet     = (r.tx_st == sdlc_line_pkg::TX_IDLE) & ~r.rx_in;
      want_half = r.ctrl[`CTL_CRC32] | r.ctrl[`CTL_HALF];

      // ============================================================
      // Bus slave: one wait cycle, then the access completes
      n.waitreq = ~acc;
      if (acc & avs_read)
      begin
         unique case (byte_addr)
            `OFS_CTRL:   n.rdata = {16'h0000, r.ctrl};
            `OFS_BAUD:   n.rdata = {16'h0000, r.baud};
            `OFS_ADDR:   n.rdata = {24'h000000, r.addr};
            `OFS_MASK:   n.rdata = {24'h000000, r.mask};
            `OFS_RXDATA: n.rdata = {24'h000000, r.rx_data};
            `OFS_STATUS: n.rdata = {22'h0, r.overrun, r.rx_in,
                                    r.eff_crc32, r.eff_half, r.align_err,
                                    r.crc_err, r.rx_done, r.rx_valid,
                                    r.tx_st != sdlc_line_pkg::TX_IDLE,
                                    r.hold_full};
            default:     n.rdata = 32'h00000000;
         endcase
      end
      if (done & avs_read & (byte_addr == `OFS_RXDATA))
         n.rx_valid = 1'b0;
      if (done & avs_write)
      begin
         unique case (byte_addr)
            `OFS_CTRL:
               n.ctrl = 16'((r.ctrl & ~wmask) | (avs_writedata & wmask));
            `OFS_BAUD:
               n.baud = 16'((r.baud & ~wmask) | (avs_writedata & wmask));
            `OFS_ADDR:
               if (avs_byteenable[0]) n.addr = avs_writedata[7:0];
            `OFS_MASK:
               if (avs_byteenable[0]) n.mask = avs_writedata[7:0];
            `OFS_TXDATA:
               if (avs_byteenable[0] & ~r.hold_full)
               begin
                  n.hold      = avs_writedata[7:0];
                  n.hold_last = avs_writedata[`TX_LAST_BIT];
                  n.hold_full = 1'b1;
               end
            `OFS_STATUS:
            begin
               if (avs_writedata[`ST_RX_DONE])   n.rx_done   = 1'b0;
               if (avs_writedata[`ST_CRC_ERR])   n.crc_err   = 1'b0;
               if (avs_writedata[`ST_ALIGN_ERR]) n.align_err = 1'b0;
               if (avs_writedata[`ST_OVERRUN])   n.overrun   = 1'b0;
            end
            default:
               n.rdata = r.rdata;
         endcase
      end

      // ============================================================
      // Mode selection, latched only between frames
      if (quiet & ((want_half != r.eff_half)
                   | (r.ctrl[`CTL_CRC32] != r.eff_crc32)))
      begin
         n.eff_half  = want_half;
         n.eff_crc32 = r.ctrl[`CTL_CRC32];
         mode_chg    = 1'b1;
      end

      // ============================================================
      // Bit-rate divider
      n.tick = 1'b0;
      if (r.div == 16'h0000)
      begin
         n.tick = 1'b1;
         n.div  = r.ctrl[`CTL_BRG] ? r.baud : 16'h0000;
      end
      else
         n.div = r.div - 16'h0001;

      // ============================================================
      // Transmitter; nothing is ever relayed from rxd to txd
      unique case (r.tx_st)
         sdlc_line_pkg::TX_CRC:  tx_bit = r.crc_sh[31];
         sdlc_line_pkg::TX_IDLE: tx_bit = 1'b1;
         default:                tx_bit = r.tx_sh[0];
      endcase
      if (r.tick)
      begin
         n.txd     = nrzi ? (tx_bit ? r.txd : ~r.txd) : tx_bit;
         n.tx_sh   = {1'b0, r.tx_sh[7:1]};
         n.crc_sh  = {r.crc_sh[30:0], 1'b0};
         n.tx_bits = r.tx_bits + 5'h01;
         unique case (r.tx_st)
            sdlc_line_pkg::TX_IDLE:
            begin
               n.tx_bits = 5'h00;
               // Half duplex waits while the receiver is in frame state (rx_in), which only switching the receiver off clears
               if (r.hold_full & r.ctrl[`CTL_TEN] & ~mode_chg
                   & ~(r.eff_half & r.rx_in))
               begin
                  tx_clr     = 1'b1;
                  n.pre_left = r.ctrl[`CTL_PRE_HI:`CTL_PRE_LO];
                  n.tx_sh    = `FLAG_BYTE;
                  n.tx_st    = sdlc_line_pkg::TX_OPEN;
                  if (r.ctrl[`CTL_PRE_HI:`CTL_PRE_LO] != 4'h0)
                  begin
                     n.pre_left = r.ctrl[`CTL_PRE_HI:`CTL_PRE_LO] - 4'h1;
                     n.tx_sh    = `PRE_BYTE;
                     n.tx_st    = sdlc_line_pkg::TX_PRE;
                  end
               end
            end
            sdlc_line_pkg::TX_PRE:
               if (byte_end)
               begin
                  n.tx_sh = `PRE_BYTE;
                  if (r.pre_left == 4'h0)
                  begin
                     n.tx_sh = `FLAG_BYTE;
                     n.tx_st = sdlc_line_pkg::TX_OPEN;
                  end
                  else
                     n.pre_left = r.pre_left - 4'h1;
               end
            sdlc_line_pkg::TX_OPEN, sdlc_line_pkg::TX_DATA:
               if (byte_end)
               begin
                  // Whole bytes only; running dry ends the frame
                  if ((r.tx_st == sdlc_line_pkg::TX_OPEN)
                      | (~r.tx_last & r.hold_full))
                  begin
                     tx_en       = 1'b1;
                     n.tx_sh     = r.hold;
                     n.tx_last   = r.hold_last;
                     n.hold_full = 1'b0;
                     n.tx_st     = sdlc_line_pkg::TX_DATA;
                  end
                  else
                  begin
                     n.crc_sh  = r.eff_crc32 ? ~crc_w
                                             : {~crc_w[15:0], 16'h0000};
                     n.tx_bits = 5'h00;
                     n.tx_st   = sdlc_line_pkg::TX_CRC;
                  end
               end
            sdlc_line_pkg::TX_CRC:
               if (r.tx_bits == (r.eff_crc32 ? `CRC32_BITS : `CRC16_BITS))
               begin
                  n.tx_sh   = `FLAG_BYTE;
                  n.tx_bits = 5'h00;
                  n.tx_st   = sdlc_line_pkg::TX_CLOSE;
               end
            sdlc_line_pkg::TX_CLOSE:
               if (byte_end)
                  n.tx_st = sdlc_line_pkg::TX_IDLE;
         endcase
      end

      // ============================================================
      // Receiver
      n.rx_s1 = rxd;
      n.rx_s2 = r.rx_s1;
      if (r.tick & rx_on)
      begin
         n.rx_prev = r.rx_s2;
         n.rx_sh   = sh_next;
         if (sh_next == `FLAG_BYTE)
         begin
            if (r.rx_in & r.rx_got)
            begin
               n.rx_done = 1'b1;
               if (r.rx_cnt != 3'h7)
                  n.align_err = 1'b1;
               if (r.rx_acc & ~rx_match)
                  n.crc_err = 1'b1;
            end
            // Idle fill flags simply restart; the next byte is an address
            rx_clr   = 1'b1;
            n.rx_in  = 1'b1;
            n.rx_cnt = 3'h0;
            n.rx_got = 1'b0;
            n.rx_acc = 1'b0;
            n.pend_n = 2'h0;
         end
         else if (r.rx_in)
         begin
            n.rx_cnt = r.rx_cnt + 3'h1;
            if (r.rx_cnt == 3'h7)
            begin
               ok_addr = (sh_next == `BCAST_ADDR)
                         | (((sh_next ^ r.addr) & ~r.mask) == 8'h00);
               n.rx_got = 1'b1;
               if (r.rx_got ? r.rx_acc : ok_addr)
               begin
                  n.rx_acc = 1'b1;
                  rx_en    = 1'b1;
                  // Two-byte delay keeps the 16-bit check bytes from software; with the 32-bit check the first two of four still reach it
                  n.pend0  = sh_next;
                  n.pend1  = r.pend0;
                  if (r.pend_n == 2'h2)
                  begin
                     n.rx_data  = r.pend1;
                     n.rx_valid = 1'b1;
                     if (r.rx_valid)
                        n.overrun = 1'b1;
                  end
                  else
                     n.pend_n = r.pend_n + 2'h1;
               end
            end
         end
      end
      if (~rx_on)
         n.rx_in = 1'b0;
      // Acknowledge and CSMA bits are kept only for readback and never
      // refuse a combination, nor track sequence counts
      n.ctrl[`CTL_HW_ACK] = n.ctrl[`CTL_HW_ACK];
   end

   // ============================================================
   // State register
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         r <= CORE_RST;
      else
         r <= n;
   end

   assign avs_readdata    = r.rdata;
   assign avs_waitrequest = r.waitreq;
   assign txd             = r.txd;

endmodule : frame_serial_controller

// ===== tb/frame_ctrl_monitor.sv
`timescale 1ns/10ps
// ==========
// Bus timing and mode checks on the controller ports
module frame_ctrl_monitor (
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic [2:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        rxd,
   input wire logic        txd
);
   logic [15:0] ctrl_r;
   logic        st_rd;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   assign st_rd = avs_read && !avs_waitrequest && avs_address == 3'h6;
   // Shadow of the control word; bench always writes all lanes
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         ctrl_r <= 16'h0000;
      else if (avs_write && !avs_waitrequest && avs_address == 3'h0)
         ctrl_r <= avs_writedata[15:0];
   end
   chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("no answer after one wait cycle");
   chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low for more than one cycle");
   chk_wait_idle: assert property (!(avs_read || avs_write)
      |=> avs_waitrequest) else $error("wait low without a request");
   chk_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
      && avs_address == 3'h7 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   chk_reset_quiet: assert property ($rose(rst_b) |-> txd && avs_waitrequest
      && avs_readdata == 32'h0) else $error("outputs not at reset level");
   chk_wide_half: assert property (st_rd && avs_readdata[7] |->
      avs_readdata[6]) else $error("wide check without half duplex");
   chk_half_req: assert property (st_rd && avs_readdata[6]
      && !avs_readdata[7] |-> ctrl_r[2])
      else $error("half duplex not requested");
   chk_ctrl_back: assert property (avs_read && !avs_waitrequest
      && avs_address == 3'h0 |-> (avs_readdata & 32'h0000F3FF)
      == {16'h0, ctrl_r & 16'hF3FF}) else $error("control readback");
   cover property (st_rd && avs_readdata[7]);
   cover property ($fell(txd));
   cover property (avs_write && !avs_waitrequest);
endmodule : frame_ctrl_monitor

bind frame_serial_controller frame_ctrl_monitor frame_ctrl_monitor_i (
   .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .rxd(rxd), .txd(txd));

// ===== tb/remote_station.sv
`timescale 1ns/10ps
// ==========
// Remote station on the receive line, NRZI coded, idles at mark
module remote_station #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic ref_clk,
   output logic      line
);
   logic        lvl = 1'b1;
   logic [15:0] crc;
   initial line = 1'b1;
   task put_bit(input logic b);
      if (!b)
         lvl = ~lvl;
      line <= lvl;
      repeat (BIT_CLKS) @(posedge ref_clk);
   endtask : put_bit
   task put_byte(input logic [7:0] v, input logic fcs);
      logic f;
      for (int i = 0; i < 8; i++)
      begin
         f = crc[15] ^ v[i];
         if (fcs)
            crc = {crc[14:0], 1'b0} ^ (f ? 16'h1021 : 16'h0000);
         put_bit(v[i]);
      end
   endtask : put_byte
   // Bad check only when a scenario asks for it
   task send_frame(input logic [7:0] pre, input int npre, input int nflag,
                   input logic [31:0] d, input int n, input logic bad);
      for (int i = 0; i < nflag; i++)
         put_byte(8'h7E, 1'b0);
      for (int i = 0; i < npre; i++)
         put_byte(pre, 1'b0);
      put_byte(8'h7E, 1'b0);
      crc = 16'hFFFF;
      for (int i = 0; i < n; i++)
         put_byte(d[8*i+:8], 1'b1);
      crc = ~crc ^ {15'h0, bad};
      for (int i = 15; i >= 0; i--)
         put_bit(crc[i]);
      put_byte(8'h7E, 1'b0);
   endtask : send_frame
endmodule : remote_station

// ===== tb/tb.sv
`timescale 1ns/10ps
// ==========
// Controller bench
module tb;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [2:0]  avs_address = 3'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        txd;
   logic        line;
   logic        loop_en = 1'b0;
   logic        rxd;
   logic [31:0] rd;
   int          err_count = 0;
   int          num_checks = 0;
   int          cyc = 0;
   // Half duplex ties the transmitter back onto the receiver
   assign rxd = loop_en ? txd : line;
   always #2 ref_clk = ~ref_clk;
   frame_serial_controller frame_serial_controller_i (.ref_clk(ref_clk),
      .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd));
   remote_station #(.BIT_CLKS(16)) remote_station_i (.ref_clk(ref_clk),
      .line(line));
   // ==========
   // Shared tasks
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: %s got %h want %h", $time, m, seen, exp);
      end
   endtask : check
   task bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
      int n;
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge ref_clk);
      n = 0;
      // The loop assumes no cycle count and only the watchdog ends a hang; the count is then checked to be one
      while (avs_waitrequest !== 1'b0)
      begin
         n++;
         @(posedge ref_clk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
      check(n, 32'h1, "wait cycles");
   endtask : bus
   task wr(input logic [2:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rdc(input logic [2:0] a, input logic [31:0] mk, input logic [31:0] e,
            input string m);
      bus(1'b0, a, 32'h0);
      check(rd & mk, e, m);
   endtask : rdc
   task wait_st(input int b, input logic v);
      int n;
      for (n = 0; n < 2000; n++)
      begin
         bus(1'b0, 3'h6, 32'h0);
         if (rd[b] === v)
            break;
      end
      if (n == 2000)
         check(32'h1, 32'h0, "status wait");
   endtask : wait_st
   task rx_take(input logic [31:0] d, input int n);
      for (int i = 0; i < n; i++)
      begin
         wait_st(2, 1'b1);
         rdc(3'h5, 32'hFF, {24'h0, d[8*i+:8]}, "rx byte");
      end
   endtask : rx_take
   // Leaving the frame state needs the receiver off for a moment
   task rx_arm;
      wr(3'h0, 32'h0081);
      wr(3'h6, 32'h238);
      wr(3'h0, 32'h0089);
   endtask : rx_arm
   task wait_low;
      int n;
      for (n = 0; n < 60 && txd !== 1'b0; n++)
         @(posedge ref_clk);
   endtask : wait_low
   // ==========
   // Scenarios
   task s_regs;
      rdc(3'h0, 32'hFFFFFFFF, 32'h0, "ctrl reset");
      rdc(3'h6, 32'hFFFFFFFF, 32'h0, "status reset");
      wr(3'h7, 32'hFFFF);
      rdc(3'h7, 32'hFFFFFFFF, 32'h0, "unmapped");
      wr(3'h0, 32'h0303);
      rdc(3'h0, 32'hF3FF, 32'h0303, "option mix");
      rdc(3'h6, 32'hC0, 32'hC0, "wide check");
      wr(3'h0, 32'h0001);
      rdc(3'h6, 32'hC0, 32'h00, "narrow check");
      wr(3'h0, 32'h0005);
      rdc(3'h6, 32'hC0, 32'h40, "half request");
   endtask : s_regs
   task s_tx_nrz;
      logic [55:0] fb;
      logic [15:0] c;
      fb = {8'h7E, 16'h0, 8'hAB, 8'h7E, 16'h5555};
      c = 16'hFFFF;
      for (int i = 0; i < 8; i++)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ fb[24+i]) ? 16'h1021 : 16'h0);
      for (int i = 0; i < 16; i++)
         fb[32+i] = ~c[15-i];
      wr(3'h0, 32'h2041);
      wr(3'h4, 32'h1AB);
      wait_low;
      for (int k = 2; k < 56; k++)
      begin
         @(posedge ref_clk);
         check({31'h0, txd}, {31'h0, fb[k]}, "tx bit");
      end
      wait_st(1, 1'b0);
   endtask : s_tx_nrz
   task s_tx_nrzi;
      logic lv;
      // Bit period is the divisor plus one, so two clocks per bit
      wr(3'h1, 32'h1);
      wr(3'h0, 32'h10C1);
      wr(3'h4, 32'h1AB);
      wait_low;
      lv = 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         repeat (3) @(posedge ref_clk);
         check({31'h0, txd}, {31'h0, lv}, "nrzi hold");
         @(posedge ref_clk);
         lv = ~lv;
         check({31'h0, txd}, {31'h0, lv}, "nrzi edge");
      end
      wait_st(1, 1'b0);
   endtask : s_tx_nrzi
   task s_rx;
      wr(3'h1, 32'hF);
      wr(3'h2, 32'h42);
      wr(3'h3, 32'h0);
      rx_arm;
      fork
         remote_station_i.send_frame(8'h00, 2, 0, 32'h3CFF, 2, 1'b0);
         rx_take(32'h3CFF, 2);
      join
      wait_st(3, 1'b1);
      rdc(3'h6, 32'h10, 32'h0, "good check");
      rx_arm;
      remote_station_i.send_frame(8'h00, 1, 0, 32'h1142, 2, 1'b1);
      wait_st(3, 1'b1);
      rdc(3'h6, 32'h10, 32'h10, "bad check");
      wr(3'h2, 32'h55);
      rx_arm;
      bus(1'b0, 3'h5, 32'h0);
      remote_station_i.send_frame(8'h55, 3, 2, 32'h42, 1, 1'b0);
      rdc(3'h5, 32'hFF, 32'h55, "preamble as address");
   endtask : s_rx
   task s_half;
      loop_en <= 1'b1;
      wr(3'h2, 32'h42);
      wr(3'h0, 32'h10C5);
      wr(3'h6, 32'h238);
      wr(3'h0, 32'h10CD);
      wr(3'h4, 32'h042);
      wait_st(0, 1'b0);
      wr(3'h4, 32'h1A5);
      rx_take(32'hA542, 2);
      wr(3'h0, 32'h10C5);
      wr(3'h6, 32'h238);
      wr(3'h4, 32'h1FF);
      wait_st(1, 1'b1);
      wait_st(1, 1'b0);
      rdc(3'h6, 32'h0C, 32'h0, "receiver off");
      loop_en <= 1'b0;
   endtask : s_half
   // ==========
   // Main sequence and watchdog
   initial
   begin
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      s_regs;
      s_tx_nrz;
      s_tx_nrzi;
      s_rx;
      s_half;
      report_and_stop;
   end
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         report_and_stop;
      end
   end
endmodule : tb
